// ==== include/dcl_defs.vh ====
// Constants for the correction and nonvolatile configuration latches.
// Assumes the including file supplies mclk at 200 MHz.
//
// Functional notes
// - Hold a 21-bit correction latch setting the current ratio of three outputs.
// - Latch address 1110b selects the correction latch.
// - After reset the correction latch is loaded from nonvolatile memory.
// - Serial correction writes are accepted only while the write-enable bit is 1.
// - With write-enable 0 the latch keeps nonvolatile values and ignores writes.
// - Channel 0 is bits 6-0, channel 1 bits 13-7, channel 2 bits 20-14.
// - Bits 35-21 of a correction write are discarded.
// - Both nonvolatile write latches are 36 bits wide.
// - The second write latch programs the stored correction defaults.
// - Latch address 1100b selects the first nonvolatile write latch.
// - Config bits 2-0 hold converter maximum duty, default 0h.
// - Config bits 7-3 hold the feedback target code, default 00h.
// - Config bits 9-8 hold the link timing mode, default 0h.
// - Timing mode 00 is mode 0, 01 mode 1, 10 and 11 mode 2.
// - Config bits 13-10 hold the latch pulse delay, default Fh.
// - Config bits 27-14 are never retained in nonvolatile memory.
`ifndef DCL_DEFS_VH
`define DCL_DEFS_VH

`define DCL_ADDR_W 4
`define DCL_DATA_W 36
`define DCL_LAST_BIT 6'd39

`define DCL_ADDR_CFG 4'hC
`define DCL_ADDR_DEFCORR 4'hD
`define DCL_ADDR_CORR 4'hE

`define DCL_CORR_W 21
`define DCL_CH_W 7
`define DCL_CH0_MSB 6
`define DCL_CH0_LSB 0
`define DCL_CH1_MSB 13
`define DCL_CH1_LSB 7
`define DCL_CH2_MSB 20
`define DCL_CH2_LSB 14

`define DCL_DUTY_MSB 2
`define DCL_DUTY_LSB 0
`define DCL_FB_MSB 7
`define DCL_FB_LSB 3
`define DCL_MODE_MSB 9
`define DCL_MODE_LSB 8
`define DCL_DELAY_MSB 13
`define DCL_DELAY_LSB 10
`define DCL_STORED_MSB 13
`define DCL_CMD_MSB 35
`define DCL_CMD_LSB 28
`define DCL_WR_CMD 8'hA5

`define DCL_CFG_FACTORY 36'h000003C00
`define DCL_CORR_FACTORY 36'h0001FFFFF

`define DCL_NV_IDX_CFG 1'b0
`define DCL_NV_IDX_CORR 1'b1

`define DCL_MCLK_MHZ 200
`define DCL_IDLE_NS 2000
`define DCL_IDLE_CYC ((`DCL_IDLE_NS * `DCL_MCLK_MHZ + 999) / 1000)

`endif

// ==== logic/dcl_latches.v ====
// Correction latch and nonvolatile configuration write latches.
// Assumes sck_in and sdt_in arrive asynchronously from the upstream chain,
// and corr_write_enable comes from the function control latch on mclk.
`timescale 1ns/1ps
`default_nettype none
`include "dcl_defs.vh"

module dcl_latches (
  input wire mclk,
  input wire rst,
  input wire sck_in,
  input wire sdt_in,
  input wire corr_write_enable,
  output wire [`DCL_CH_W-1:0] corr_ch0,
  output wire [`DCL_CH_W-1:0] corr_ch1,
  output wire [`DCL_CH_W-1:0] corr_ch2,
  output reg [2:0] converter_max_duty,
  output reg [4:0] feedback_target_code,
  output reg [1:0] link_timing_mode,
  output reg [3:0] latch_pulse_delay,
  output wire [`DCL_DATA_W-1:0] nv_config_latch,
  output wire [`DCL_DATA_W-1:0] nv_correction_default_latch,
  output reg frame_done_ff,
  output reg nv_cmd_error_ff,
  output wire nv_busy
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Timing mode field to selected mode number
  function [1:0] dcl_mode_decode;
    input [1:0] code;
    begin
      case (code)
        2'h0: dcl_mode_decode = 2'h0;
        2'h1: dcl_mode_decode = 2'h1;
        default: dcl_mode_decode = 2'h2;
      endcase
    end
  endfunction

  // Frame address match
  function dcl_addr_is;
    input [`DCL_ADDR_W-1:0] addr;
    input [`DCL_ADDR_W-1:0] code;
    begin
      dcl_addr_is = (addr == code);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // States

  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_RD_CORR = 6'h02;
  localparam [5:0] ST_LD_CORR = 6'h04;
  localparam [5:0] ST_RD_CFG = 6'h08;
  localparam [5:0] ST_LD_CFG = 6'h10;
  localparam [5:0] ST_PROG = 6'h20;

  localparam integer IDLE_CYC_FULL = `DCL_IDLE_CYC;
  localparam [9:0] IDLE_CYC = IDLE_CYC_FULL[9:0];

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  reg sck_m_ff;
  reg sck_s_ff;
  reg sck_d_ff;
  reg sdt_m_ff;
  reg sdt_s_ff;
  wire sck_rise;

  reg [39:0] shift_ff;
  reg [5:0] bit_cnt_ff;
  reg [9:0] idle_cnt_ff;
  reg [`DCL_ADDR_W-1:0] frame_addr_ff;
  reg [`DCL_DATA_W-1:0] frame_data_ff;
  wire [39:0] shift_next;

  reg [5:0] state_ff;
  reg [5:0] nxt_state;
  reg boot_ff;

  reg [`DCL_CORR_W-1:0] corr_ff;
  reg [`DCL_DATA_W-1:0] cfg_latch_ff;
  reg [`DCL_DATA_W-1:0] def_latch_ff;
  reg prog_idx_ff;
  reg [`DCL_DATA_W-1:0] prog_data_ff;

  reg nv_re;
  reg nv_we;
  reg nv_addr;
  wire [`DCL_DATA_W-1:0] nv_rdata;

  wire hit_cfg;
  wire hit_def;
  wire hit_corr;
  wire cmd_ok;
  wire in_idle;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and link clock edge

  always @(posedge mclk) begin
    if (rst) begin
      sck_m_ff <= 1'b0;
      sck_s_ff <= 1'b0;
      sck_d_ff <= 1'b0;
      sdt_m_ff <= 1'b0;
      sdt_s_ff <= 1'b0;
    end else begin
      sck_m_ff <= sck_in;
      sck_s_ff <= sck_m_ff;
      sck_d_ff <= sck_s_ff;
      sdt_m_ff <= sdt_in;
      sdt_s_ff <= sdt_m_ff;
    end
  end

  assign sck_rise = sck_s_ff & ~sck_d_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Serial frame: 4-bit address then 36 data bits, MSB first

  assign shift_next = {shift_ff[38:0], sdt_s_ff};

  always @(posedge mclk) begin
    if (rst) begin
      shift_ff <= 40'h0000000000;
      bit_cnt_ff <= 6'h00;
      idle_cnt_ff <= 10'h000;
      frame_addr_ff <= 4'h0;
      frame_data_ff <= 36'h000000000;
      frame_done_ff <= 1'b0;
    end else begin
      frame_done_ff <= 1'b0;
      if (sck_rise) begin
        idle_cnt_ff <= 10'h000;
        shift_ff <= shift_next;
        if (bit_cnt_ff == `DCL_LAST_BIT) begin
          bit_cnt_ff <= 6'h00;
          frame_addr_ff <= shift_next[39:36];
          frame_data_ff <= shift_next[35:0];
          frame_done_ff <= 1'b1;
        end else begin
          bit_cnt_ff <= bit_cnt_ff + 6'h01;
        end
      end else if (idle_cnt_ff == IDLE_CYC) begin
        bit_cnt_ff <= 6'h00;
      end else begin
        idle_cnt_ff <= idle_cnt_ff + 10'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  assign hit_cfg = dcl_addr_is(frame_addr_ff, `DCL_ADDR_CFG);
  assign hit_def = dcl_addr_is(frame_addr_ff, `DCL_ADDR_DEFCORR);
  assign hit_corr = dcl_addr_is(frame_addr_ff, `DCL_ADDR_CORR);
  assign cmd_ok = (frame_data_ff[`DCL_CMD_MSB:`DCL_CMD_LSB] == `DCL_WR_CMD);
  assign in_idle = (state_ff == ST_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: power-on preload and programming

  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (frame_done_ff && hit_cfg && cmd_ok) begin
          nxt_state = ST_PROG;
        end else if (frame_done_ff && hit_def) begin
          nxt_state = ST_PROG;
        end
      end
      ST_PROG: begin
        if (prog_idx_ff == `DCL_NV_IDX_CFG) begin
          nxt_state = ST_RD_CFG;
        end else begin
          nxt_state = ST_RD_CORR;
        end
      end
      ST_RD_CORR: begin
        nxt_state = ST_LD_CORR;
      end
      ST_LD_CORR: begin
        if (boot_ff) begin
          nxt_state = ST_RD_CFG;
        end else begin
          nxt_state = ST_IDLE;
        end
      end
      ST_RD_CFG: begin
        nxt_state = ST_LD_CFG;
      end
      ST_LD_CFG: begin
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always @* begin
    nv_re = 1'b0;
    nv_we = 1'b0;
    nv_addr = `DCL_NV_IDX_CFG;
    case (state_ff)
      ST_PROG: begin
        nv_we = 1'b1;
        nv_addr = prog_idx_ff;
      end
      ST_RD_CORR: begin
        nv_re = 1'b1;
        nv_addr = `DCL_NV_IDX_CORR;
      end
      ST_RD_CFG: begin
        nv_re = 1'b1;
        nv_addr = `DCL_NV_IDX_CFG;
      end
      default: begin
        nv_re = 1'b0;
      end
    endcase
  end

  always @(posedge mclk) begin
    if (rst) begin
      state_ff <= ST_RD_CORR;
      boot_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      if (state_ff == ST_LD_CFG) begin
        boot_ff <= 1'b0;
      end
    end
  end

  assign nv_busy = ~in_idle;

  ////////////////////////////////////////////////////////////////////////////
  // Write latches and programming data

  always @(posedge mclk) begin
    if (rst) begin
      cfg_latch_ff <= 36'h000000000;
      def_latch_ff <= 36'h000000000;
      prog_idx_ff <= `DCL_NV_IDX_CFG;
      prog_data_ff <= 36'h000000000;
      nv_cmd_error_ff <= 1'b0;
    end else begin
      nv_cmd_error_ff <= 1'b0;
      if (in_idle && frame_done_ff && hit_cfg) begin
        cfg_latch_ff <= frame_data_ff;
        if (cmd_ok) begin
          prog_idx_ff <= `DCL_NV_IDX_CFG;
          prog_data_ff <= {22'h000000, frame_data_ff[`DCL_STORED_MSB:0]};
        end else begin
          nv_cmd_error_ff <= 1'b1;
        end
      end else if (in_idle && frame_done_ff && hit_def) begin
        def_latch_ff <= frame_data_ff;
        prog_idx_ff <= `DCL_NV_IDX_CORR;
        prog_data_ff <= {15'h0000, frame_data_ff[`DCL_CORR_W-1:0]};
      end
    end
  end

  assign nv_config_latch = cfg_latch_ff;
  assign nv_correction_default_latch = def_latch_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Correction latch

  always @(posedge mclk) begin
    if (rst) begin
      corr_ff <= 21'h000000;
    end else if (state_ff == ST_LD_CORR) begin
      if (boot_ff || !corr_write_enable) begin
        corr_ff <= nv_rdata[`DCL_CORR_W-1:0];
      end
    end else if (in_idle && frame_done_ff && hit_corr && corr_write_enable) begin
      corr_ff <= frame_data_ff[`DCL_CORR_W-1:0];
    end
  end

  // Writes with enable low fall through above and leave the latch alone
  // Upper frame bits never reach the latch

  assign corr_ch0 = corr_ff[`DCL_CH0_MSB:`DCL_CH0_LSB];
  assign corr_ch1 = corr_ff[`DCL_CH1_MSB:`DCL_CH1_LSB];
  assign corr_ch2 = corr_ff[`DCL_CH2_MSB:`DCL_CH2_LSB];

  ////////////////////////////////////////////////////////////////////////////
  // Configuration outputs from stored word

  always @(posedge mclk) begin
    if (rst) begin
      converter_max_duty <= 3'h0;
      feedback_target_code <= 5'h00;
      link_timing_mode <= 2'h0;
      latch_pulse_delay <= 4'hF;
    end else if (state_ff == ST_LD_CFG) begin
      converter_max_duty <= nv_rdata[`DCL_DUTY_MSB:`DCL_DUTY_LSB];
      feedback_target_code <= nv_rdata[`DCL_FB_MSB:`DCL_FB_LSB];
      link_timing_mode <= dcl_mode_decode(nv_rdata[`DCL_MODE_MSB:`DCL_MODE_LSB]);
      latch_pulse_delay <= nv_rdata[`DCL_DELAY_MSB:`DCL_DELAY_LSB];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Nonvolatile store

  dcl_nv_store dcl_nv_store_i (
    .mclk(mclk),
    .re(nv_re),
    .we(nv_we),
    .addr(nv_addr),
    .wdata(prog_data_ff),
    .rdata_ff(nv_rdata)
  );

endmodule
`default_nettype wire

// ==== logic/dcl_nv_store.v ====
// Two-word nonvolatile store model: configuration word and correction defaults.
// Assumes one access per cycle; read data appear one cycle after re.
`timescale 1ns/1ps
`default_nettype none
`include "dcl_defs.vh"

module dcl_nv_store (
  input wire mclk,
  input wire re,
  input wire we,
  input wire addr,
  input wire [`DCL_DATA_W-1:0] wdata,
  output reg [`DCL_DATA_W-1:0] rdata_ff
);

  reg [`DCL_DATA_W-1:0] mem [0:1];

  // Factory contents, kept across reset
  initial begin
    mem[0] = `DCL_CFG_FACTORY;
    mem[1] = `DCL_CORR_FACTORY;
  end

  always @(posedge mclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    if (re) begin
      rdata_ff <= mem[addr];
    end
  end

endmodule
`default_nettype wire

// ==== verif/dcl_latches_properties.sv ====
// Checker on the ports of dcl_latches.
// Assumes mclk and synchronous active-high rst.
`timescale 1ns/1ps
`default_nettype none
`include "dcl_defs.vh"
module dcl_latches_props (
  input wire logic mclk,
  input wire logic rst,
  input wire logic corr_write_enable,
  input wire logic [`DCL_CH_W-1:0] corr_ch0,
  input wire logic [`DCL_CH_W-1:0] corr_ch1,
  input wire logic [`DCL_CH_W-1:0] corr_ch2,
  input wire logic [2:0] converter_max_duty,
  input wire logic [4:0] feedback_target_code,
  input wire logic [1:0] link_timing_mode,
  input wire logic [3:0] latch_pulse_delay,
  input wire logic [`DCL_DATA_W-1:0] nv_config_latch,
  input wire logic frame_done_ff,
  input wire logic nv_cmd_error_ff,
  input wire logic nv_busy
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  wire [20:0] corr = {corr_ch2, corr_ch1, corr_ch0};
  wire [13:0] cfg = {latch_pulse_delay, link_timing_mode, feedback_target_code, converter_max_duty};
  property p_rst_preload;
    $past(rst) |-> ##[0:6] !nv_busy;
  endproperty
  a_rst_preload: assert property (p_rst_preload) else $error("preload too slow");
  property p_corr_src;
    !$stable(corr) |-> $past(frame_done_ff) || $past(nv_busy);
  endproperty
  a_corr_src: assert property (p_corr_src) else $error("correction changed unprompted");
  property p_corr_hold;
    frame_done_ff && !corr_write_enable && !nv_busy |=> $stable(corr);
  endproperty
  a_corr_hold: assert property (p_corr_hold) else $error("correction written while locked");
  property p_mode;
    link_timing_mode != 2'h3;
  endproperty
  a_mode: assert property (p_mode) else $error("timing mode out of range");
  property p_cfg_src;
    !$stable(cfg) |-> $past(nv_busy);
  endproperty
  a_cfg_src: assert property (p_cfg_src) else $error("config changed outside reload");
  property p_prog_walk;
    $rose(nv_busy) |-> nv_busy [*3] ##1 !nv_busy;
  endproperty
  a_prog_walk: assert property (p_prog_walk) else $error("program sequence length");
  property p_cmd_err;
    nv_cmd_error_ff |-> ##[0:1] nv_config_latch[35:28] != 8'hA5;
  endproperty
  a_cmd_err: assert property (p_cmd_err) else $error("error flag with good command");
  property p_err_noprog;
    nv_cmd_error_ff |-> !nv_busy ##1 !nv_busy;
  endproperty
  a_err_noprog: assert property (p_err_noprog) else $error("bad command programmed");
  c_corr_wr: cover property (frame_done_ff && corr_write_enable);
  c_cmd_err: cover property (nv_cmd_error_ff);
  c_prog: cover property ($rose(nv_busy));
endmodule
bind dcl_latches dcl_latches_props dcl_latches_props_i (
  .mclk(mclk),
  .rst(rst),
  .corr_write_enable(corr_write_enable),
  .corr_ch0(corr_ch0),
  .corr_ch1(corr_ch1),
  .corr_ch2(corr_ch2),
  .converter_max_duty(converter_max_duty),
  .feedback_target_code(feedback_target_code),
  .link_timing_mode(link_timing_mode),
  .latch_pulse_delay(latch_pulse_delay),
  .nv_config_latch(nv_config_latch),
  .frame_done_ff(frame_done_ff),
  .nv_cmd_error_ff(nv_cmd_error_ff),
  .nv_busy(nv_busy)
);
`default_nettype wire

// ==== verif/dcl_latches_test.sv ====
// Self-checking bench for dcl_latches with the upstream model.
// Assumes the nonvolatile store starts with factory contents.
`timescale 1ns/1ps
`default_nettype none
`include "dcl_defs.vh"
module dcl_latches_test;
  logic mclk, rst, corr_write_enable;
  logic [35:0] w;
  logic [13:0] ec;
  integer fail_count = 0, cmp_count = 0, done_n = 0, err_n = 0, n0, m;
  wire sck_in, sdt_in, frame_done_ff, nv_cmd_error_ff, nv_busy;
  wire [`DCL_CH_W-1:0] corr_ch0, corr_ch1, corr_ch2;
  wire [2:0] converter_max_duty;
  wire [4:0] feedback_target_code;
  wire [1:0] link_timing_mode;
  wire [3:0] latch_pulse_delay;
  wire [35:0] nv_config_latch, nv_correction_default_latch;
  wire [20:0] corr = {corr_ch2, corr_ch1, corr_ch0};
  wire [13:0] cfg = {latch_pulse_delay, link_timing_mode, feedback_target_code, converter_max_duty};
  dcl_up_model dcl_up_model_i (.mclk(mclk), .sck_in(sck_in), .sdt_in(sdt_in));
  dcl_latches dcl_latches_i (
    .mclk(mclk), .rst(rst), .sck_in(sck_in), .sdt_in(sdt_in),
    .corr_write_enable(corr_write_enable), .corr_ch0(corr_ch0), .corr_ch1(corr_ch1),
    .corr_ch2(corr_ch2), .converter_max_duty(converter_max_duty),
    .feedback_target_code(feedback_target_code), .link_timing_mode(link_timing_mode),
    .latch_pulse_delay(latch_pulse_delay), .nv_config_latch(nv_config_latch),
    .nv_correction_default_latch(nv_correction_default_latch),
    .frame_done_ff(frame_done_ff), .nv_cmd_error_ff(nv_cmd_error_ff), .nv_busy(nv_busy));
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (frame_done_ff === 1'b1) done_n <= done_n + 1;
    if (nv_cmd_error_ff === 1'b1) err_n <= err_n + 1;
  end
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic send(input logic [3:0] a, input logic [35:0] d);
    n0 = done_n;
    dcl_up_model_i.frame({a, d}, 40);
    repeat (12) @(negedge mclk);
    chk(36'(done_n - n0), 36'h1);
  endtask
  task automatic final_report;
    $display("compares %0d errors %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    fail_count++;
    final_report;
  end
  initial begin
    rst = 1'b1;
    corr_write_enable = 1'b0;
    repeat (20) @(negedge mclk);
    rst = 1'b0;
    repeat (8) @(negedge mclk);
    chk(corr, 21'h1FFFFF);
    chk(cfg, 14'h3C00);
    chk(nv_busy, 36'h0);
    send(4'hE, 36'h000000ABC);
    chk(corr, 21'h1FFFFF);
    corr_write_enable = 1'b1;
    dcl_up_model_i.frame(40'hE000000000, 20);
    repeat (450) @(negedge mclk);
    send(4'hE, {15'h7FFF, 7'h12, 7'h34, 7'h56});
    chk(corr_ch0, 7'h56);
    chk(corr_ch1, 7'h34);
    chk(corr_ch2, 7'h12);
    send(4'hF, 36'h0);
    chk(corr, {7'h12, 7'h34, 7'h56});
    for (m = 0; m < 4; m++) begin
      w = {8'hA5, 14'h3FFF, 4'(m + 5), 2'(m), 5'h1A + 5'(m), 3'(7 - m)};
      ec = {4'(m + 5), (m > 1) ? 2'h2 : 2'(m), 5'h1A + 5'(m), 3'(7 - m)};
      send(4'hC, w);
      chk(nv_config_latch, w);
      chk(cfg, ec);
    end
    w = {8'h5A, 28'h0};
    send(4'hC, w);
    chk(nv_config_latch, w);
    chk(cfg, ec);
    chk(36'(err_n), 36'h1);
    corr_write_enable = 1'b0;
    w = {15'h7FFF, 7'h11, 7'h22, 7'h33};
    send(4'hD, w);
    chk(nv_correction_default_latch, w);
    chk(corr, w[20:0]);
    rst = 1'b1;
    repeat (3) @(negedge mclk);
    rst = 1'b0;
    repeat (8) @(negedge mclk);
    chk(corr, w[20:0]);
    chk(cfg, ec);
    chk(nv_busy, 36'h0);
    chk(nv_config_latch, 36'h0);
    final_report;
  end
endmodule
`default_nettype wire

// ==== verif/dcl_up_model.sv ====
// Upstream controller: shifts 40-bit frames into the link.
// Assumes mclk at 200 MHz; the link clock runs at 80 ns only inside frames.
`timescale 1ns/1ps
`default_nettype none
module dcl_up_model (
  input wire logic mclk,
  output var logic sck_in,
  output var logic sdt_in
);
  initial begin
    sck_in = 1'b0;
    sdt_in = 1'b0;
  end
  // MSB first, data changes while the clock is low
  task automatic frame(input logic [39:0] w, input integer n);
    integer i;
    for (i = 39; i > 39 - n; i--) begin
      @(negedge mclk);
      sdt_in = w[i];
      repeat (7) @(negedge mclk);
      sck_in = 1'b1;
      repeat (8) @(negedge mclk);
      sck_in = 1'b0;
    end
    @(negedge mclk);
    sdt_in = ~sdt_in;
  endtask
endmodule
`default_nettype wire
